// File: rtl/rswc_params.svh
/*
   Constants of the reset status, debug forced reset, options and watchdog block.
   Assumes inclusion by bare name from the package and from the top module.
*/
`ifndef RSWC_PARAMS_SVH
`define RSWC_PARAMS_SVH

// Status bit positions
`define RSWC_ST_POR        7
`define RSWC_ST_PIN        6
`define RSWC_ST_WDG        5
`define RSWC_ST_OPC        4
`define RSWC_ST_ADR        3
`define RSWC_ST_OSC        2
`define RSWC_ST_UV         1
`define RSWC_POR_VALUE     8'h82

// Options register fields
`define RSWC_OPT_TO_HI     7
`define RSWC_OPT_TO_LO     6
`define RSWC_OPT_HALT      5
`define RSWC_OPT_I2C       3
`define RSWC_OPT_MASK      8'hE8
`define RSWC_OPT_RESET     8'hC0

// Force reset bit in the debug forced reset register
`define RSWC_DBG_FORCE     0

// Service values
`define RSWC_SVC_FIRST     8'h55
`define RSWC_SVC_SECOND    8'hAA

// Slow clock timeouts, period of one slow tick in ms
`define RSWC_LPO_MS        1
`define RSWC_LPO_T1_MS     32
`define RSWC_LPO_T2_MS     256
`define RSWC_LPO_T3_MS     1024

`define RSWC_CNT_W         19

`endif

// File: rtl/rswc_pkg.sv
/*
   Types of the reset status and watchdog block.
   Assumes nothing beyond the constants header.
*/
package rswc_pkg;
`include "rswc_params.svh"

   // Register select codes of the access port
   typedef enum logic [1:0] {
      RSWC_REG_STATUS = 2'h0,
      RSWC_REG_DBGFR  = 2'h1,
      RSWC_REG_OPT1   = 2'h2,
      RSWC_REG_NONE   = 2'h3
   } rswc_reg_e;

   // Service sequence state
   typedef enum logic {
      RSWC_SVC_IDLE  = 1'b0,
      RSWC_SVC_ARMED = 1'b1
   } rswc_svc_e;

   typedef logic [`RSWC_CNT_W-1:0] rswc_cnt_t;

endpackage : rswc_pkg

// File: rtl/rswc_top.sv
/*
   Reset cause capture, debug forced reset, write-once options and watchdog.
   Assumes one 50 MHz clock, a one-cycle slow tick every 1 ms, and a system
   reset controller that asserts rst after reset_req and por on power-up.
*/
`timescale 1ns/1ps
`include "rswc_params.svh"

module rswc_top
   import rswc_pkg::*;
#(
   parameter int BUS_T1_CYC  = 8192,
   parameter int BUS_T2_CYC  = 65536,
   parameter int BUS_T3_CYC  = 262144,
   parameter int BUS_W1_CYC  = 6144,
   parameter int BUS_W2_CYC  = 49152,
   parameter int BUS_W3_CYC  = 196608
)
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       por,
   // Program access
   input  wire logic [1:0] cpu_sel,
   input  wire logic       cpu_wr,
   input  wire logic [7:0] cpu_wdata,
   output logic      [7:0] cpu_rdata,
   // Debug link memory write
   input  wire logic [1:0] dbg_sel,
   input  wire logic       dbg_wr,
   input  wire logic [7:0] dbg_wdata,
   // Reset sources and qualifiers
   input  wire logic       ext_reset_n,
   input  wire logic       bad_opcode,
   input  wire logic       halt_exec,
   input  wire logic       debug_halt_exec,
   input  wire logic       debug_mode_enable,
   input  wire logic       bad_address,
   input  wire logic       ref_osc_failure,
   input  wire logic       undervoltage_trip,
   input  wire logic       undervoltage_reset_enable,
   input  wire logic       watchdog_master_enable,
   input  wire logic       watchdog_clock_select,
   input  wire logic       watchdog_window_enable,
   input  wire logic       lpo_tick,
   // Results
   output logic            reset_req,
   output logic            halt_enter,
   output logic            halt_mode_enable,
   output logic            i2c_line_location_select,
   output logic      [3:0] i2c_line_enable
);

   //==========================================================================
   // Timeout decode
   //==========================================================================
   // Slow clock limits are kept in ticks of the 1 ms pulse, so the counter
   // width is set by the longest bus clock period, not by these
   localparam rswc_cnt_t LPO_T1 = rswc_cnt_t'(`RSWC_LPO_T1_MS / `RSWC_LPO_MS);
   localparam rswc_cnt_t LPO_T2 = rswc_cnt_t'(`RSWC_LPO_T2_MS / `RSWC_LPO_MS);
   localparam rswc_cnt_t LPO_T3 = rswc_cnt_t'(`RSWC_LPO_T3_MS / `RSWC_LPO_MS);

   // Overflow count for a timeout code and clock choice
   // A zero code returns zero, which the enable logic never lets count
   function automatic rswc_cnt_t wdg_limit(input logic [1:0] code, input logic bus);
      rswc_cnt_t lim;
      lim = '0;
      case (code)
         2'h1:    lim = bus ? rswc_cnt_t'(BUS_T1_CYC) : LPO_T1;
         2'h2:    lim = bus ? rswc_cnt_t'(BUS_T2_CYC) : LPO_T2;
         2'h3:    lim = bus ? rswc_cnt_t'(BUS_T3_CYC) : LPO_T3;
         default: lim = '0;
      endcase
      return lim;
   endfunction : wdg_limit

   // Window open count; the slow clock never windows
   // Zero for the slow clock keeps every write clear of the window test
   function automatic rswc_cnt_t wdg_open(input logic [1:0] code, input logic bus);
      rswc_cnt_t w;
      w = '0;
      if (bus)
      begin
         case (code)
            2'h1:    w = rswc_cnt_t'(BUS_W1_CYC);
            2'h2:    w = rswc_cnt_t'(BUS_W2_CYC);
            2'h3:    w = rswc_cnt_t'(BUS_W3_CYC);
            default: w = '0;
         endcase
      end
      return w;
   endfunction : wdg_open

   //==========================================================================
   // Options register
   //==========================================================================
   logic [7:0] opt1;
   logic       opt1_locked;
   logic       opt1_wr;
   assign opt1_wr = cpu_wr && (rswc_reg_e'(cpu_sel) == RSWC_REG_OPT1);

   // First write after reset wins, later ones are dropped
   // Locking on any write, even one of default values, stops a runaway
   // program from quietly changing the watchdog or halt settings
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         opt1        <= `RSWC_OPT_RESET;
         opt1_locked <= 1'b0;
      end
      else if (opt1_wr && !opt1_locked)
      begin
         opt1        <= cpu_wdata & `RSWC_OPT_MASK;
         opt1_locked <= 1'b1;
      end
   end

   logic [1:0] to_code;
   assign to_code          = opt1[`RSWC_OPT_TO_HI:`RSWC_OPT_TO_LO];
   assign halt_mode_enable = opt1[`RSWC_OPT_HALT];

   // Pin routing follows the latched option bit
   // One cycle behind the register, which only matters right after
   // the single options write
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         i2c_line_location_select <= 1'b0;
      else
         i2c_line_location_select <= opt1[`RSWC_OPT_I2C];
   end

   // Enables order: port F line 2, F line 3, E line 4, E line 5
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_i2c
         assign i2c_line_enable[gi] = (gi >= 2) ? i2c_line_location_select
                                                : !i2c_line_location_select;
      end
   endgenerate

   //==========================================================================
   // Watchdog
   //==========================================================================
   // Watchdog state and decoded limits
   logic      wdg_on;
   logic      use_bus;
   rswc_cnt_t limit;
   rswc_cnt_t wopen;
   rswc_cnt_t wdg_cnt;
   rswc_svc_e svc;
   logic      st_wr;
   logic      svc_restart;
   logic      wdg_bad_write;
   logic      wdg_expire;

   // Watchdog blocked by master enable or a zero code
   assign wdg_on  = watchdog_master_enable && (to_code != 2'h0);
   assign use_bus = watchdog_clock_select;
   assign limit   = wdg_limit(to_code, use_bus);
   assign wopen   = wdg_open(to_code, use_bus);
   assign st_wr   = cpu_wr && (rswc_reg_e'(cpu_sel) == RSWC_REG_STATUS);

   // Second half of the pair restarts only after an armed first half
   // One bit of history only, so 0x55, 0x55, 0xAA still restarts
   assign svc_restart = st_wr && (svc == RSWC_SVC_ARMED)
                        && (cpu_wdata == `RSWC_SVC_SECOND);

   // Window only guards the bus clock, early writes are fatal
   always_comb
   begin
      wdg_bad_write = 1'b0;
      if (wdg_on && st_wr)
      begin
         if ((cpu_wdata != `RSWC_SVC_FIRST) && (cpu_wdata != `RSWC_SVC_SECOND))
            wdg_bad_write = 1'b1;
         if (watchdog_window_enable && use_bus && (wdg_cnt < wopen))
            wdg_bad_write = 1'b1;
      end
   end

   // Overflow when the counter reaches its last count and advances
   // Comparing against limit minus one lets the request leave on the
   // edge of the overflowing count, saving a cycle of latency
   assign wdg_expire = wdg_on && (wdg_cnt == limit - 1'b1)
                       && (use_bus || lpo_tick);

   // Service pair tracking; a stray write drops the armed state
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         svc <= RSWC_SVC_IDLE;
      else if (st_wr)
      begin
         if (cpu_wdata == `RSWC_SVC_FIRST)
            svc <= RSWC_SVC_ARMED;
         else
            svc <= RSWC_SVC_IDLE;
      end
   end

   // Counter runs only while enabled, restarts on service
   // Counting past the limit is harmless: the reset controller clears
   // the counter through rst long before it could wrap
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         wdg_cnt <= '0;
      else if (!wdg_on || svc_restart)
         wdg_cnt <= '0;
      else if (use_bus || lpo_tick)
         wdg_cnt <= wdg_cnt + 1'b1;
   end

   //==========================================================================
   // Reset sources
   //==========================================================================
   logic [7:0] cause;
   logic       dbg_force;
   logic       opc_fault;

   // Halt and debug halt become bad opcodes when not allowed
   assign opc_fault = bad_opcode
                      || (halt_exec && !halt_mode_enable)
                      || (debug_halt_exec && !debug_mode_enable);

   // Only the debug link reaches the force bit; program writes are dropped
   assign dbg_force = dbg_wr && (rswc_reg_e'(dbg_sel) == RSWC_REG_DBGFR)
                      && dbg_wdata[`RSWC_DBG_FORCE];

   // Cause vector; power-up is caught by the por reset value
   // Sources are levels; one that stays active keeps the request
   // and the status capture going every cycle
   always_comb
   begin
      cause                = 8'h00;
      cause[`RSWC_ST_PIN]  = !ext_reset_n;
      cause[`RSWC_ST_WDG]  = wdg_expire || wdg_bad_write;
      cause[`RSWC_ST_OPC]  = opc_fault;
      cause[`RSWC_ST_ADR]  = bad_address;
      cause[`RSWC_ST_OSC]  = ref_osc_failure;
      cause[`RSWC_ST_UV]   = undervoltage_trip && undervoltage_reset_enable;
   end

   // Reset request is a registered pulse to the reset controller
   // Registered so a glitch on a combinational source cannot reach
   // the reset controller
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         reset_req <= 1'b0;
      else
         reset_req <= (|cause) || dbg_force;
   end

   // Halt entry allowed only with halt mode enabled
   // A refused halt shows up as a bad opcode instead, never both
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         halt_enter <= 1'b0;
      else
         halt_enter <= halt_exec && halt_mode_enable;
   end

   //==========================================================================
   // Status register
   //==========================================================================
   logic [7:0] status;

   // Kept across ordinary resets so software can read the cause;
   // a debug forced reset alone records no flag
   // A power-up load wins over everything since por is asynchronous
   always_ff @(posedge clk or posedge por)
   begin
      if (por)
         status <= `RSWC_POR_VALUE;
      else if ((|cause) || dbg_force)
         status <= cause;
   end

   //==========================================================================
   // Read port
   //==========================================================================
   // One cycle read latency; force register always reads zero
   // Reads have no side effects, so polling the status is always safe
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cpu_rdata <= 8'h00;
      else
      begin
         case (rswc_reg_e'(cpu_sel))
            RSWC_REG_STATUS: cpu_rdata <= status;
            RSWC_REG_DBGFR:  cpu_rdata <= 8'h00;
            RSWC_REG_OPT1:   cpu_rdata <= opt1;
            default:         cpu_rdata <= 8'h00;
         endcase
      end
   end

endmodule : rswc_top

// File: dv/rswc_asserts.sv
/* Checker of reset causes, debug force, halt and I2C routing.
   Assumes the top module's ports only; bound after the module. */
`timescale 1ns/1ps
module rswc_chk
   import rswc_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic [1:0] cpu_sel,
   input wire logic [7:0] cpu_rdata,
   input wire logic [1:0] dbg_sel,
   input wire logic       dbg_wr,
   input wire logic [7:0] dbg_wdata,
   input wire logic       ext_reset_n,
   input wire logic       bad_opcode,
   input wire logic       halt_exec,
   input wire logic       debug_halt_exec,
   input wire logic       debug_mode_enable,
   input wire logic       bad_address,
   input wire logic       ref_osc_failure,
   input wire logic       undervoltage_trip,
   input wire logic       undervoltage_reset_enable,
   input wire logic       reset_req,
   input wire logic       halt_enter,
   input wire logic       halt_mode_enable,
   input wire logic       i2c_line_location_select,
   input wire logic [3:0] i2c_line_enable
);
   // ==========
   // Properties
   // One domain, so clock and disable are shared
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_DBGRD: assert property ($past(cpu_sel) == RSWC_REG_DBGFR |-> cpu_rdata == 8'h00)
      else $error("debug force register read not zero");
   AST_FORCE: assert property (dbg_wr && dbg_sel == RSWC_REG_DBGFR && dbg_wdata[0]
      |=> reset_req) else $error("debug force gave no reset");
   AST_PIN: assert property (!ext_reset_n |=> reset_req)
      else $error("pin gave no reset");
   AST_OPC: assert property (bad_opcode || (halt_exec && !halt_mode_enable)
      || (debug_halt_exec && !debug_mode_enable) |=> reset_req)
      else $error("bad opcode gave no reset");
   AST_ADR: assert property (bad_address |=> reset_req)
      else $error("bad address gave no reset");
   AST_OSC: assert property (ref_osc_failure |=> reset_req)
      else $error("clock loss gave no reset");
   AST_UV: assert property (undervoltage_trip && undervoltage_reset_enable |=> reset_req)
      else $error("undervoltage gave no reset");
   AST_HALT: assert property (halt_exec && halt_mode_enable |=> halt_enter)
      else $error("halt not entered");
   AST_I2C: assert property (i2c_line_enable == (i2c_line_location_select ? 4'hC : 4'h3))
      else $error("I2C lines wrongly routed");
   cover property (reset_req ##1 !reset_req);
   cover property (halt_enter);
   cover property (dbg_wr && dbg_sel == RSWC_REG_DBGFR);
endmodule : rswc_chk
bind rswc_top rswc_chk i_chk (.*);

// File: dv/rswc_dbg_host.sv
/* Debug host model: one force-reset write on the debug link per request.
   Assumes one-cycle requests from the bench, spaced apart. */
`timescale 1ns/1ps
module rswc_dbg_host
   import rswc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       fire,
   input  wire logic [1:0] lag,
   output logic      [1:0] dbg_sel,
   output logic            dbg_wr,
   output logic      [7:0] dbg_wdata
);
   // ==========
   // Link driver
   // Idle data walks each cycle, so no stale byte passes for a command
   initial
   begin
      dbg_sel   = RSWC_REG_NONE;
      dbg_wr    = 1'b0;
      dbg_wdata = 8'h00;
   end
   always @(posedge clk)
   begin
      if (fire)
      begin
         repeat (lag) @(posedge clk);
         #1;
         dbg_sel   = RSWC_REG_DBGFR;
         dbg_wr    = 1'b1;
         dbg_wdata = 8'h01;
         @(posedge clk);
      end
      #1;
      dbg_sel   = RSWC_REG_NONE;
      dbg_wr    = 1'b0;
      dbg_wdata = {dbg_wdata[6:0], ~dbg_wdata[7]};
   end
endmodule : rswc_dbg_host

// File: dv/tb_top.sv
/* Bench: scoreboard reads, reset causes, debug force, options, watchdog.
   Assumes shortened bus counts and a slow tick every 4 clocks. */
`timescale 1ns/1ps
module tb_top;
   import rswc_pkg::*;
   // ==========
   // Signals
   logic       clk = 1'b0, rst = 1'b1, por = 1'b1, cpu_wr = 1'b0, halt_exec = 1'b0;
   logic       uv_en = 1'b0, wme = 1'b0, wcs = 1'b0, wwe = 1'b0, lpo = 1'b0;
   logic       fire = 1'b0, rd_req = 1'b0, reset_req, halt_enter, hme, ref_osc_failure_flag, dbg_wr;
   logic       dme = 1'b0, hit = 1'b0, pin_n, opc, dhalt, badadr, oscf, uvt;
   logic [1:0] cpu_sel = 2'h3, lag = 2'h0, dbg_sel;
   logic [7:0] cpu_wdata = 8'h00, cpu_rdata, dbg_wdata, d;
   logic [7:0] exp_q [$];
   logic [7:0] tbl [6] = '{8'h40, 8'h10, 8'h10, 8'h08, 8'h04, 8'h02};
   logic [5:0] src = 6'h00;
   logic [3:0] ien;
   int         fail_count, cmp_count, cyc, n;
   integer     seed = 32'hAA686A14;
   // Pin, opcode, debug halt, address, clock and undervoltage lines, all from the walking source vector
   assign pin_n = ~src[0];
   assign {uvt, oscf, badadr, dhalt, opc} = src[5:1];
   rswc_top #(.BUS_T1_CYC(64), .BUS_T2_CYC(512), .BUS_T3_CYC(2048),
      .BUS_W1_CYC(48), .BUS_W2_CYC(384), .BUS_W3_CYC(1536)) i_dut (
      .clk(clk), .rst(rst), .por(por), .cpu_sel(cpu_sel), .cpu_wr(cpu_wr),
      .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .dbg_sel(dbg_sel),
      .dbg_wr(dbg_wr), .dbg_wdata(dbg_wdata), .ext_reset_n(pin_n),
      .bad_opcode(opc), .halt_exec(halt_exec), .debug_halt_exec(dhalt),
      .debug_mode_enable(dme), .bad_address(badadr), .ref_osc_failure(oscf),
      .undervoltage_trip(uvt), .undervoltage_reset_enable(uv_en),
      .watchdog_master_enable(wme), .watchdog_clock_select(wcs),
      .watchdog_window_enable(wwe), .lpo_tick(lpo), .reset_req(reset_req),
      .halt_enter(halt_enter), .halt_mode_enable(hme),
      .i2c_line_location_select(ref_osc_failure_flag), .i2c_line_enable(ien));
   rswc_dbg_host i_host (.clk(clk), .fire(fire), .lag(lag), .dbg_sel(dbg_sel),
      .dbg_wr(dbg_wr), .dbg_wdata(dbg_wdata));
   // Clock, shortened slow tick and hang ceiling
   always #10 clk = ~clk;
   always @(posedge clk) #1 lpo = (cyc % 4 == 0);
   // Requests last one cycle, so they are caught as they pass
   always @(negedge clk)
      if (reset_req === 1'b1)
         hit = 1'b1;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         fail_count++;
         give_verdict();
      end
   end
   // ==========
   // Tasks
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : step
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [1:0] s, input logic [7:0] v);
      cpu_sel   = s;
      cpu_wdata = v;
      cpu_wr    = 1'b1;
      step(1);
      cpu_wr = 1'b0;
      step(1);
   endtask : wr
   // Strobe held over the pair, so no other write splits it
   task automatic svc();
      cpu_sel   = RSWC_REG_STATUS;
      cpu_wdata = 8'h55;
      cpu_wr    = 1'b1;
      step(1);
      cpu_wdata = 8'hAA;
      step(1);
      cpu_wr = 1'b0;
      step(1);
   endtask : svc
   task automatic rd(input logic [1:0] s, input logic [7:0] e);
      cpu_sel = s;
      rd_req  = 1'b1;
      exp_q.push_back(e);
      step(1);
      rd_req = 1'b0;
      step(1);
   endtask : rd
   // Any request since the previous check counts, so a pulse that
   // left during the stimulus task itself is not lost
   task automatic req(input logic e);
      step(8);
      chk(hit, e);
      hit = 1'b0;
   endtask : req
   task automatic reboot();
      rst = 1'b1;
      hit = 1'b0;
      step(1);
      rst = 1'b0;
   endtask : reboot
   task automatic wdg(input logic bus, input int c);
      int lim;
      lim = (bus ? 64 : 128) << (c == 1 ? 0 : c == 2 ? 3 : 5);
      reboot();
      wr(RSWC_REG_OPT1, {2'(c), 6'h00});
      wcs = bus;
      wme = 1'b1;
      n   = 0;
      while (reset_req !== 1'b1 && n < 5000)
      begin
         step(1);
         n++;
      end
      wme = 1'b0;
      chk(n > lim - 6 && n < lim + 6, 1'b1);
      rd(RSWC_REG_STATUS, 8'h20);
   endtask : wdg
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   // Result watcher: oldest note against each read answer
   always @(posedge clk)
      if (rd_req === 1'b1)
      begin
         @(negedge clk);
         chk(cpu_rdata, exp_q.pop_front());
      end
   // ==========
   // Scenarios
   initial
   begin
      step(3);
      rst = 1'b0;
      por = 1'b0;
      rd(RSWC_REG_STATUS, 8'h82);
      rd(RSWC_REG_OPT1, 8'hC0);
      halt_exec = 1'b1;
      step(1);
      halt_exec = 1'b0;
      req(1'b1);
      rd(RSWC_REG_STATUS, 8'h10);
      wr(RSWC_REG_OPT1, 8'h28);
      wr(RSWC_REG_OPT1, 8'hFF);
      rd(RSWC_REG_OPT1, 8'h28);
      chk({hme, ref_osc_failure_flag, ien}, 6'h3C);
      halt_exec = 1'b1;
      step(1);
      halt_exec = 1'b0;
      chk(halt_enter, 1'b1);
      req(1'b0);
      wr(RSWC_REG_DBGFR, 8'h01);
      req(1'b0);
      rd(RSWC_REG_DBGFR, 8'h00);
      wme = 1'b1;
      wcs = 1'b1;
      d   = 8'($random(seed));
      wr(RSWC_REG_STATUS, d);
      step(100);
      req(1'b0);
      wme   = 1'b0;
      uv_en = 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         src = 6'h01 << i;
         step(1);
         src = 6'h00;
         req(1'b1);
         rd(RSWC_REG_STATUS, tbl[i]);
      end
      uv_en = 1'b0;
      src   = 6'h20;
      step(1);
      src = 6'h00;
      req(1'b0);
      dme = 1'b1;
      src = 6'h04;
      step(1);
      src = 6'h00;
      req(1'b0);
      dme  = 1'b0;
      lag  = 2'($random(seed));
      fire = 1'b1;
      step(1);
      fire = 1'b0;
      req(1'b1);
      rd(RSWC_REG_STATUS, 8'h00);
      for (int i = 0; i < 6; i++)
         wdg(i < 3, i % 3 + 1);
      reboot();
      wr(RSWC_REG_OPT1, 8'h80);
      wcs = 1'b1;
      wwe = 1'b1;
      wme = 1'b1;
      repeat (2)
      begin
         repeat (50) req(1'b0);
         svc();
      end
      req(1'b0);
      rd(RSWC_REG_STATUS, 8'h20);
      step(100);
      wr(RSWC_REG_STATUS, 8'h55);
      req(1'b1);
      reboot();
      wr(RSWC_REG_OPT1, 8'h80);
      wwe = 1'b0;
      d   = 8'($random(seed));
      if (d == 8'h55 || d == 8'hAA)
         d = 8'h00;
      wr(RSWC_REG_STATUS, d);
      req(1'b1);
      reboot();
      wr(RSWC_REG_OPT1, 8'h40);
      wme = 1'b0;
      step(200);
      req(1'b0);
      por = 1'b1;
      reboot();
      por = 1'b0;
      rd(RSWC_REG_STATUS, 8'h82);
      give_verdict();
   end
endmodule : tb_top
